// ---- sli_status_led.sv ----
// How it works
// - run indicator steady while executing with key in run or step-run
// - run flickers on stopping error or stop-to-run after program write
// - post-write flicker ends only on run-stop-run or key-switch reset
// - error steady for continuing error other than battery or program-fault items, flicker on stopping error
// - program-fault lit by check or annunciator, flickers during latch clear
// - battery alarm lit by continuing-error item 9; CPU or card low battery only raises its interrupt
// - startup-load lit once boot transfer completes, dark otherwise
// - reset instruction clears error, program-fault, battery; not startup-load
// - error reset with code clears the same three, continuing errors only
// - rising edge of off request clears selected program-fault or startup-load
// - select bit 1 clears: 100H startup-load, 10H program-fault, 110H both
// - stopping error always indicated regardless of priority
// - continuing errors indicated by order held in three priority registers
// - equal priority: first detected error is indicated
// - default order item 1 to A
// - removed item lights no indicator; three indicators share order
// - diagnostic flags and error code kept even when suppressed
`timescale 1ns/1ps
`default_nettype none
module sli_status_led #(
    parameter int           NI = sli_pkg::NITEM
) (
    input  wire logic           clk,
    input  wire logic           srst,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hsel,
    input  wire logic           hready,
    output logic [31:0]         hrdata,
    output logic                hreadyout,
    output logic                hresp,
    input  wire logic           keyRun,
    input  wire logic           keyStep,
    input  wire logic           keyReset,
    input  wire logic           progWritten,
    input  wire logic           stopError,
    input  wire logic [NI-1:0]  contErrorEvt,
    input  wire logic [15:0]    contErrorCode,
    input  wire logic           latchClearBusy,
    input  wire logic           batLowCpu,
    input  wire logic           batLowCard,
    input  wire logic           bootDone,
    output logic                ledRun,
    output logic                ledError,
    output logic                ledUser,
    output logic                batteryAlarmIndicator,
    output logic                ledBoot,
    output logic                irq
);
    import sli_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change when stages 2 and 3 agree
    localparam int NPIN = 8;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] s1_q;
    logic [NPIN-1:0] s2_q;
    logic [NPIN-1:0] s3_q;
    logic [NPIN-1:0] pin_q;
    assign pinRaw = {bootDone, batLowCard, batLowCpu, latchClearBusy,
                     stopError, progWritten, keyReset, keyRun | keyStep};
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            pin_q <= '0;
        end else begin
            s1_q <= pinRaw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < NPIN; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    pin_q[i] <= s3_q[i];
                end
            end
        end
    end
    logic runKey, keyRst, progWr, stopErr, latchClr, batCpu, batCard, boot;
    assign {boot, batCard, batCpu, latchClr, stopErr, progWr, keyRst, runKey} = pin_q;

    logic [NI-1:0] ce1_q, ce2_q, ce3_q, ceSync_q, cePrev_q, ceRise;
    always_ff @(posedge clk) begin
        if (srst) begin
            ce1_q    <= '0;
            ce2_q    <= '0;
            ce3_q    <= '0;
            ceSync_q <= '0;
            cePrev_q <= '0;
        end else begin
            ce1_q    <= contErrorEvt;
            ce2_q    <= ce1_q;
            ce3_q    <= ce2_q;
            cePrev_q <= ceSync_q;
            for (int i = 0; i < NI; i++) begin
                if (ce2_q[i] == ce3_q[i]) begin
                    ceSync_q[i] <= ce3_q[i];
                end
            end
        end
    end
    assign ceRise = ceSync_q & ~cePrev_q;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY
    logic        wrPend_q;
    logic [7:0]  wrAddr_q;
    logic [15:0] offSel_q, prioA_q, prioB_q, prioC_q, rstCode_q;
    logic [15:0] diagCode_q;
    logic [31:0] blinkHalf_q;
    logic [IRQ_W-1:0] irqStat_q, irqEn_q, irqEvt;
    logic        ctlLedr, ctlErrRst, offReq_q, offReqPrev_q;
    logic        addrOk;
    assign addrOk = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    function automatic logic wr(input logic [7:0] off);
        return wrPend_q && wrAddr_q == off;
    endfunction

    always_ff @(posedge clk) begin
        if (srst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
        end else begin
            wrPend_q <= addrOk & hwrite;
            wrAddr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            offSel_q    <= '0;
            prioA_q     <= PRIO_A_RST;
            prioB_q     <= PRIO_B_RST;
            prioC_q     <= PRIO_C_RST;
            rstCode_q   <= '0;
            blinkHalf_q <= BLINK_CYC;
            irqEn_q     <= '0;
            offReq_q    <= 1'b0;
        end else begin
            if (wr(OFF_OFFSEL))  offSel_q    <= hwdata[15:0];
            if (wr(OFF_PRIO_A))  prioA_q     <= hwdata[15:0];
            if (wr(OFF_PRIO_B))  prioB_q     <= hwdata[15:0];
            if (wr(OFF_PRIO_C))  prioC_q     <= hwdata[15:0];
            if (wr(OFF_RSTCODE)) rstCode_q   <= hwdata[15:0];
            if (wr(OFF_BLINK))   blinkHalf_q <= hwdata;
            if (wr(OFF_IRQEN))   irqEn_q     <= hwdata[IRQ_W-1:0];
            if (wr(OFF_CTRL))    offReq_q    <= hwdata[CTL_OFFREQ];
        end
    end
    // written out: a continuous assign does not see what a function reads implicitly
    assign ctlLedr   = wrPend_q && wrAddr_q == OFF_CTRL && hwdata[CTL_INDICATOR_RESET_INSTRUCTION];
    assign ctlErrRst = wrPend_q && wrAddr_q == OFF_CTRL && hwdata[CTL_ERRRST];

    always_ff @(posedge clk) begin
        if (srst) offReqPrev_q <= 1'b0;
        else      offReqPrev_q <= offReq_q;
    end
    logic offEdge;
    assign offEdge = offReq_q & ~offReqPrev_q;

    ////////////////////////////////////////////////////////////////////////
    // priority: rank of an item, 0 when removed from the order
    logic [47:0] prioAll;
    assign prioAll = {prioC_q, prioB_q, prioA_q};
    function automatic logic [3:0] rankOf(input logic [3:0] item, input logic [47:0] p);
        logic [3:0] r;
        r = '0;
        for (int k = 11; k >= 0; k--) begin
            if (p[k*4 +: 4] == item) r = 4'(k + 1);
        end
        return r;
    endfunction

    // pending continuing errors, latched until cleared
    logic [NI-1:0] pend_q, pendClr;
    logic [NI-1:0] ordMask;
    always_comb begin
        ordMask = '0;
        for (int i = 0; i < NI; i++) begin
            ordMask[i] = rankOf(4'(i + 1), prioAll) != '0;
        end
    end
    assign pendClr = (ctlLedr | ctlErrRst) ? '1 : '0;
    always_ff @(posedge clk) begin
        if (srst) pend_q <= '0;
        else      pend_q <= ceRise | (pend_q & ~pendClr); // set wins
    end

    // first-detected among equal rank: keep current winner while still valid
    logic [3:0] win_q, winBest;
    logic [3:0] bestRank;
    always_comb begin
        winBest  = '0;
        bestRank = '0;
        for (int i = NI - 1; i >= 0; i--) begin
            if (pend_q[i] && ordMask[i]) begin
                if (bestRank == '0 || rankOf(4'(i + 1), prioAll) < bestRank) begin
                    bestRank = rankOf(4'(i + 1), prioAll);
                    winBest  = 4'(i + 1);
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            win_q <= '0;
        end else if (win_q != '0 && pend_q[win_q - 4'd1] && ordMask[win_q - 4'd1]
                     && rankOf(win_q, prioAll) == bestRank) begin
            win_q <= win_q;
        end else begin
            win_q <= winBest;
        end
    end

    // diag flags and code regardless of suppression
    logic diagFlag_q, selfFlag_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            diagFlag_q <= 1'b0;
            selfFlag_q <= 1'b0;
            diagCode_q <= '0;
        end else begin
            if (|ceRise || stopErr) begin
                diagFlag_q <= 1'b1;
                selfFlag_q <= 1'b1;
            end else if (ctlErrRst && !stopErr) begin
                diagFlag_q <= 1'b0;
                selfFlag_q <= 1'b0;
            end
            if (|ceRise) diagCode_q <= contErrorCode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // run state and indicators
    logic blink;
    sli_blinker #(.CW(32)) u_blink (
        .clk        (clk),
        .srst       (srst),
        .halfPeriod (blinkHalf_q),
        .blink      (blink)
    );

    sli_run_e runSt_q;
    logic     runPrev_q, wroteStopped_q, postWrite_q, bootLed_q, userOff_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            runSt_q        <= SLI_STOPPED;
            runPrev_q      <= 1'b0;
            wroteStopped_q <= 1'b0;
            postWrite_q    <= 1'b0;
        end else begin
            runPrev_q <= runKey;
            if (progWr && !runKey) wroteStopped_q <= 1'b1;
            if (keyRst) begin
                postWrite_q    <= 1'b0;
                wroteStopped_q <= 1'b0;
            end else if (runKey && !runPrev_q) begin
                if (postWrite_q) begin
                    postWrite_q <= 1'b0;
                end else if (wroteStopped_q) begin
                    postWrite_q    <= 1'b1;
                    wroteStopped_q <= 1'b0;
                end
            end
            unique case (runSt_q)
                SLI_STOPPED:  if (runKey) runSt_q <= SLI_RUNNING;
                SLI_RUNNING:  if (!runKey) runSt_q <= SLI_STOPPED;
                               else if (postWrite_q) runSt_q <= SLI_RUN_HOLD;
                SLI_RUN_HOLD: if (!runKey) runSt_q <= SLI_STOPPED;
                               else if (!postWrite_q) runSt_q <= SLI_RUNNING;
            endcase
        end
    end
    logic runPostFlick;
    assign runPostFlick = runSt_q == SLI_RUN_HOLD;

    always_ff @(posedge clk) begin
        if (srst) begin
            bootLed_q <= 1'b0;
            userOff_q <= 1'b0;
        end else begin
            if (boot && !bootLed_q && irqEvt[IRQ_BOOT]) bootLed_q <= 1'b1;
            else if (offEdge && offSel_q[SEL_BOOT]) bootLed_q <= 1'b0;
            if (|(ceRise & ({NI{1'b0}} | (NI'(1) << (ITEM_CHK - 4'd1)) |
                (NI'(1) << (ITEM_ANN - 4'd1))))) userOff_q <= 1'b0;
            else if (offEdge && offSel_q[SEL_USER]) userOff_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ledRun                <= 1'b0;
            ledError              <= 1'b0;
            ledUser               <= 1'b0;
            batteryAlarmIndicator <= 1'b0;
            ledBoot               <= 1'b0;
        end else begin
            if (stopErr || runPostFlick) ledRun <= blink;
            else                         ledRun <= runKey;
            if (stopErr) ledError <= blink;
            else ledError <= win_q != '0 && win_q != ITEM_CHK && win_q != ITEM_ANN
                             && win_q != ITEM_BAT;
            if (latchClr) ledUser <= blink;
            else ledUser <= !userOff_q && ((pend_q[ITEM_CHK-4'd1] && ordMask[ITEM_CHK-4'd1])
                            || (pend_q[ITEM_ANN-4'd1] && ordMask[ITEM_ANN-4'd1]));
            batteryAlarmIndicator <= pend_q[ITEM_BAT-4'd1] && ordMask[ITEM_BAT-4'd1];
            ledBoot <= bootLed_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write-1 clear, set wins
    logic batPrev_q, bootPrev_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            batPrev_q  <= 1'b0;
            bootPrev_q <= 1'b0;
        end else begin
            batPrev_q  <= batCpu | batCard;
            bootPrev_q <= boot;
        end
    end
    assign irqEvt[IRQ_STOP] = stopErr;
    assign irqEvt[IRQ_CONT] = |ceRise;
    assign irqEvt[IRQ_BAT]  = (batCpu | batCard) & ~batPrev_q;
    assign irqEvt[IRQ_BOOT] = boot & ~bootPrev_q;
    always_ff @(posedge clk) begin
        if (srst) irqStat_q <= '0;
        else if (wr(OFF_IRQCLR)) irqStat_q <= irqEvt | (irqStat_q & ~hwdata[IRQ_W-1:0]);
        else irqStat_q <= irqStat_q | irqEvt;
    end
    assign irq = |(irqStat_q & irqEn_q);

    ////////////////////////////////////////////////////////////////////////
    // read data, registered in address phase
    always_ff @(posedge clk) begin
        if (srst) begin
            hrdata <= '0;
        end else if (addrOk && !hwrite) begin
            unique case (haddr[7:0])
                OFF_OFFSEL:   hrdata <= {16'h0000, offSel_q};
                OFF_PRIO_A:   hrdata <= {16'h0000, prioA_q};
                OFF_PRIO_B:   hrdata <= {16'h0000, prioB_q};
                OFF_PRIO_C:   hrdata <= {16'h0000, prioC_q};
                OFF_RSTCODE:  hrdata <= {16'h0000, rstCode_q};
                OFF_DIAGCODE: hrdata <= {16'h0000, diagCode_q};
                OFF_LEDSTAT:  hrdata <= {25'h0, selfFlag_q, diagFlag_q, ledBoot,
                                         batteryAlarmIndicator, ledUser, ledError, ledRun};
                OFF_IRQSTAT:  hrdata <= {28'h0000000, irqStat_q};
                OFF_IRQEN:    hrdata <= {28'h0000000, irqEn_q};
                OFF_BLINK:    hrdata <= blinkHalf_q;
                default:      hrdata <= 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- sli_pkg.sv ----
package sli_pkg;
    localparam int          ADDR_W          = 8;
    // register byte offsets
    localparam logic [7:0]  OFF_CTRL        = 8'h00;
    localparam logic [7:0]  OFF_OFFSEL      = 8'h04;
    localparam logic [7:0]  OFF_PRIO_A      = 8'h08;
    localparam logic [7:0]  OFF_PRIO_B      = 8'h0C;
    localparam logic [7:0]  OFF_PRIO_C      = 8'h10;
    localparam logic [7:0]  OFF_RSTCODE     = 8'h14;
    localparam logic [7:0]  OFF_DIAGCODE    = 8'h18;
    localparam logic [7:0]  OFF_LEDSTAT     = 8'h1C;
    localparam logic [7:0]  OFF_IRQSTAT     = 8'h20;
    localparam logic [7:0]  OFF_IRQEN       = 8'h24;
    localparam logic [7:0]  OFF_IRQCLR      = 8'h28;
    localparam logic [7:0]  OFF_BLINK       = 8'h2C;
    // control register bits (bits 0-1: write 1 = one-cycle action; bit 2 held as written)
    localparam int          CTL_INDICATOR_RESET_INSTRUCTION        = 0;
    localparam int          CTL_ERRRST      = 1;
    localparam int          CTL_OFFREQ      = 2;
    // indicator-off select bits
    localparam int          SEL_USER        = 4;
    localparam int          SEL_BOOT        = 8;
    // status bits
    localparam int          ST_RUN          = 0;
    localparam int          ST_ERR          = 1;
    localparam int          ST_USER         = 2;
    localparam int          ST_BAT          = 3;
    localparam int          ST_BOOT         = 4;
    localparam int          ST_DIAG         = 5;
    localparam int          ST_SELF         = 6;
    // interrupt bits
    localparam int          IRQ_STOP        = 0;
    localparam int          IRQ_CONT        = 1;
    localparam int          IRQ_BAT         = 2;
    localparam int          IRQ_BOOT        = 3;
    localparam int          IRQ_W           = 4;
    // error items
    localparam int          NITEM           = 10;
    localparam logic [3:0]  ITEM_CHK        = 4'h6;
    localparam logic [3:0]  ITEM_ANN        = 4'h7;
    localparam logic [3:0]  ITEM_BAT        = 4'h9;
    localparam logic [15:0] PRIO_A_RST      = 16'h4321;
    localparam logic [15:0] PRIO_B_RST      = 16'h8765;
    localparam logic [15:0] PRIO_C_RST      = 16'h00A9;
    // blink half period
    localparam int          CLK_MHZ         = 250;
    localparam int          BLINK_MS        = 250;
    localparam logic [31:0] BLINK_CYC       = 32'(CLK_MHZ * 1000 * BLINK_MS);
    localparam logic [15:0] HTRANS_NONSEQ   = 16'h0002;
    typedef enum logic [1:0] {SLI_STOPPED, SLI_RUNNING, SLI_RUN_HOLD} sli_run_e;
endpackage

// ---- sli_blinker.sv ----
`timescale 1ns/1ps
`default_nettype none
module sli_blinker #(
    parameter int           CW = 32
) (
    input  wire logic           clk,
    input  wire logic           srst,
    input  wire logic [CW-1:0]  halfPeriod,
    output logic                blink
);
    logic [CW-1:0] cnt_q;

    // free-running toggle with programmable half period; every flicker output shares it
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
            blink <= 1'b0;
        end else if (cnt_q + CW'(1) >= halfPeriod) begin
            cnt_q <= '0;
            blink <= ~blink;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end
endmodule
`default_nettype wire

// ---- sli_status_led_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module sli_status_led_monitor
    import sli_pkg::*;
#(
    parameter int NI = NITEM
) (
    input wire logic          clk,
    input wire logic          srst,
    input wire logic [31:0]   haddr,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic [31:0]   hwdata,
    input wire logic          hsel,
    input wire logic          hready,
    input wire logic          hreadyout,
    input wire logic          hresp,
    input wire logic          keyRun,
    input wire logic          keyStep,
    input wire logic          stopError,
    input wire logic [NI-1:0] contErrorEvt,
    input wire logic          bootDone,
    input wire logic          ledRun,
    input wire logic          ledError,
    input wire logic          ledUser,
    input wire logic          batteryAlarmIndicator,
    input wire logic          ledBoot,
    input wire logic          irq
);
    logic       wrCtrl_q;
    logic       bootSeen_q;
    logic       errSeen_q;
    logic [3:0] idleCnt_q;
    ////////////////////////////////////////
    // data phase of a control write, so hwdata lines up with it
    always_ff @(posedge clk) begin
        wrCtrl_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == OFF_CTRL;
    end
    // history of causes; battery item deliberately left out of errSeen
    always_ff @(posedge clk) begin
        bootSeen_q <= srst ? bootDone : (bootSeen_q | bootDone);
        errSeen_q  <= srst ? 1'b0 : (errSeen_q | stopError
                      | (|{contErrorEvt[NI-1:9], contErrorEvt[7:0]}));
    end
    always_ff @(posedge clk) begin
        if (srst || keyRun || keyStep || stopError) begin
            idleCnt_q <= 4'h0;
        end else if (idleCnt_q != 4'hF) begin
            idleCnt_q <= idleCnt_q + 4'h1;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave must answer OKAY with no wait");
    a_quiet_reset: assert property (disable iff (1'b0) srst |=> !(ledRun || ledError
        || ledUser || batteryAlarmIndicator || ledBoot || irq))
        else $error("indicator lit right after reset");
    a_boot_lit: assert property ($rose(bootDone) |-> ##[1:8] ledBoot)
        else $error("boot indicator not lit after transfer");
    a_boot_cause: assert property ($rose(ledBoot) |-> bootSeen_q)
        else $error("boot indicator lit without transfer");
    a_err_cause: assert property ($rose(ledError) |-> errSeen_q)
        else $error("error indicator lit without a non-battery error");
    a_run_idle: assert property (idleCnt_q == 4'hF |-> !ledRun)
        else $error("run indicator lit while stopped");
    a_reset_clears: assert property (wrCtrl_q && (hwdata[CTL_INDICATOR_RESET_INSTRUCTION] || hwdata[CTL_ERRRST])
        && !stopError |-> ##[2:4] !(ledError || ledUser || batteryAlarmIndicator))
        else $error("indicator reset left an indicator lit");
    a_indicator_reset_instruction_boot: assert property (wrCtrl_q && hwdata[CTL_INDICATOR_RESET_INSTRUCTION] && !hwdata[CTL_OFFREQ]
        && ledBoot |=> ledBoot [*4])
        else $error("indicator reset touched boot indicator");
    c_boot: cover property ($rose(ledBoot));
    c_offreq: cover property (wrCtrl_q && hwdata[CTL_OFFREQ]);
    c_user: cover property ($rose(ledUser));
endmodule
bind sli_status_led sli_status_led_monitor #(.NI(NI)) i_mon (.clk, .srst, .haddr, .htrans,
    .hwrite, .hwdata, .hsel, .hready, .hreadyout, .hresp, .keyRun, .keyStep, .stopError,
    .contErrorEvt, .bootDone, .ledRun, .ledError, .ledUser, .batteryAlarmIndicator, .ledBoot,
    .irq);
`default_nettype wire

// ---- sli_status_led_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
    $display("Error t=%0t got %0h exp %0h", $time, (a), (e)); end end
module sli_status_led_bench;
    import sli_pkg::*;
    logic              clk, srst, hwrite, hsel, keyRun, keyStep, keyReset, progWritten;
    logic              stopError, latchClearBusy, batLowCpu, batLowCard, bootDone;
    logic              hreadyout, hresp, ledRun, ledError, ledUser, bat, ledBoot, irq;
    logic [31:0]       haddr, hwdata, hrdata, rdat;
    logic [1:0]        htrans;
    logic [NITEM-1:0]  contErrorEvt;
    logic [15:0]       contErrorCode;
    logic [15:0]       sels [3] = '{16'h0010, 16'h0100, 16'h0110};
    int                failures, checks_done, nr, ne, nu;
    sli_status_led i_dut (.clk, .srst, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hsel, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .keyRun, .keyStep, .keyReset,
        .progWritten, .stopError, .contErrorEvt, .contErrorCode, .latchClearBusy, .batLowCpu,
        .batLowCard, .bootDone, .ledRun, .ledError, .ledUser, .batteryAlarmIndicator(bat),
        .ledBoot, .irq);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        hsel   <= 1'b1;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CMP(rdat, e)
    endtask
    // pins pass a synchroniser, so give them time to land
    task automatic settle();
        repeat (12) @(posedge clk);
    endtask
    task automatic toggles();
        logic [2:0] p;
        {nr, ne, nu} = '0;
        p = {ledRun, ledError, ledUser};
        repeat (24) begin
            @(posedge clk);
            nr += int'(ledRun !== p[2]);
            ne += int'(ledError !== p[1]);
            nu += int'(ledUser !== p[0]);
            p = {ledRun, ledError, ledUser};
        end
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk);
        failures++;
        end_sim();
    end
    ////////////////////////////////////////
    initial begin
        srst = 1'b1;
        {hwrite, hsel, keyRun, keyStep, keyReset, progWritten, stopError} = '0;
        {latchClearBusy, batLowCpu, batLowCard, bootDone} = '0;
        {haddr, hwdata, htrans, contErrorEvt, contErrorCode} = '0;
        {failures, checks_done} = '0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        chk_rd(OFF_PRIO_A, 32'(PRIO_A_RST));
        chk_rd(OFF_PRIO_B, 32'(PRIO_B_RST));
        chk_rd(OFF_PRIO_C, 32'(PRIO_C_RST));
        chk_rd(8'h40, 32'h0);
        chk_rd(OFF_LEDSTAT, 32'h0);
        bus(1'b1, OFF_BLINK, 32'h4);
        for (int k = 0; k < 2; k++) begin
            {keyRun, keyStep} <= k ? 2'b01 : 2'b10;
            settle();
            toggles();
            `CMP({ledRun, nr}, {1'b1, 0})
        end
        {keyRun, keyStep} <= 2'b00;
        progWritten <= 1'b1;
        settle();
        progWritten <= 1'b0;
        keyRun <= 1'b1;
        settle();
        toggles();
        `CMP(nr > 2, 1'b1)
        keyRun <= 1'b0;
        settle();
        keyRun <= 1'b1;
        settle();
        toggles();
        `CMP({ledRun, nr}, {1'b1, 0})
        // second way out of the post-write flicker: key-switch reset
        keyRun <= 1'b0;
        progWritten <= 1'b1;
        settle();
        progWritten <= 1'b0;
        keyRun <= 1'b1;
        settle();
        toggles();
        `CMP(nr > 2, 1'b1)
        keyReset <= 1'b1;
        settle();
        keyReset <= 1'b0;
        toggles();
        `CMP({ledRun, nr}, {1'b1, 0})
        contErrorEvt <= 10'h100;
        settle();
        `CMP({bat, ledError}, 2'b10)
        bus(1'b1, OFF_RSTCODE, 32'h3100);
        bus(1'b1, OFF_CTRL, 32'h2);
        settle();
        `CMP(bat, 1'b0)
        contErrorEvt <= 10'h104;
        bootDone <= 1'b1;
        settle();
        toggles();
        `CMP({ledError, ne, ledBoot}, {1'b1, 0, 1'b1})
        bus(1'b1, OFF_CTRL, 32'h1);
        settle();
        `CMP({ledError, ledBoot}, 2'b01)
        foreach (sels[i]) begin
            contErrorEvt <= '0;
            bootDone <= 1'b0;
            settle();
            contErrorEvt <= 10'h020;
            bootDone <= 1'b1;
            settle();
            `CMP({ledUser, ledBoot}, 2'b11)
            bus(1'b1, OFF_OFFSEL, 32'(sels[i]));
            chk_rd(OFF_OFFSEL, 32'(sels[i]));
            bus(1'b1, OFF_CTRL, 32'h0);
            bus(1'b1, OFF_CTRL, 32'h4);
            settle();
            `CMP({ledUser, ledBoot}, ~{sels[i][SEL_USER], sels[i][SEL_BOOT]})
        end
        latchClearBusy <= 1'b1;
        settle();
        toggles();
        `CMP(nu > 2, 1'b1)
        latchClearBusy <= 1'b0;
        contErrorEvt <= '0;
        bus(1'b1, OFF_CTRL, 32'h1);
        bus(1'b1, OFF_PRIO_B, 32'h8705);
        contErrorCode <= 16'h2100;
        contErrorEvt <= 10'h020;
        settle();
        `CMP(ledUser, 1'b0)
        chk_rd(OFF_DIAGCODE, 32'h2100);
        bus(1'b0, OFF_LEDSTAT, 32'h0);
        `CMP(rdat[ST_DIAG], 1'b1)
        bus(1'b1, OFF_IRQEN, 32'hF);
        bus(1'b1, OFF_IRQCLR, 32'hF);
        settle();
        `CMP(irq, 1'b0)
        batLowCpu <= 1'b1;
        settle();
        `CMP(irq, 1'b1)
        chk_rd(OFF_IRQSTAT, 32'h4);
        bus(1'b1, OFF_IRQEN, 32'h0);
        batLowCpu <= 1'b0;
        settle();
        `CMP(irq, 1'b0)
        bus(1'b1, OFF_IRQCLR, 32'h4);
        bus(1'b1, OFF_IRQEN, 32'hF);
        settle();
        `CMP(irq, 1'b0)
        bus(1'b1, OFF_PRIO_A, 32'h0);
        bus(1'b1, OFF_PRIO_B, 32'h0);
        bus(1'b1, OFF_PRIO_C, 32'h0);
        stopError <= 1'b1;
        settle();
        toggles();
        `CMP({nr > 2, ne > 2, irq}, 3'b111)
        end_sim();
    end
endmodule
`default_nettype wire
